// ==== core/oad_dac_if.sv ====
/*
  oad_dac_if: backplane register port, octal pair selection, octal to
  serial-audio conversion and converter clock generation for an
  eight-converter analog output card.
  Assumes clk is much faster than the strobe port; the bus master clock and
  word clock are sampled as ordinary inputs through two flip-flops.
*/
`timescale 1ns/100ps

// Summary of operation
// - two byte registers, slot select, address bit
// - write latched at strobe rising edge
// - five control outputs driven from register
// - global mute low forces zero serial data
// - identity register read only, type and revision
// - source select resets to three; three zeroes
// - control bit 4 drives de-emphasis
// - control bit 3 drives relay mute low
// - control bit 2 drives converter reset low
// - control bit 1 drives soft mute
// - control bit 0 drives double rate
// - reset gives default registers and outputs
// - converter clocks derived from bus clocks
// - master clock 256 or 128 times fs
// - octal line bit rate fixed by word clock
// - eight slots of 24-bit samples per frame
// - mux one line pair into eight streams
// - right true, left complemented same frame
// - odd channels first line, even second
// - double speed: four samples per line
// - single speed uses last four slots
// - word clock rising edge starts octal frame
// - frame sync and bit clock fall start
module oad_dac_if #(
  // arbitrary neutral identity value
  parameter logic [7:0] BOARD_IDENTITY = 8'h5a
) (
  // system
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // backplane register port
  input wire logic slot_select_n,
  input wire logic backplane_addr_bit,
  input wire logic transfer_direction,
  input wire logic transfer_strobe_n,
  input wire logic [7:0] backplane_data_bus_in,
  output logic [7:0] backplane_data_bus_out,
  output logic backplane_data_bus_oe,
  // bus clocks and octal lines
  input wire logic bus_master_clk,
  input wire logic bus_word_clk,
  input wire logic [oad_pkg::NUM_LINES-1:0] octal_in_line,
  input wire logic all_mute_n,
  // converter controls
  output logic emphasis_undo_en,
  output logic converter_soft_mute,
  output logic converter_reset_n,
  output logic double_rate_en,
  output logic relay_mute_n,
  // converter serial audio
  output logic conv_master_clk,
  output logic conv_bit_clk_n,
  output logic conv_frame_sync_n,
  output logic [oad_pkg::NUM_CH-1:0] conv_serial_data
);

  oad_pkg::oad_state_t st_reg;
  oad_pkg::oad_state_t st_next;
  oad_pkg::oad_pins_t raw;
  logic mrise;
  logic wrise;
  logic wr_fire;
  logic half_start;
  logic [1:0] src;
  logic line_odd;
  logic line_even;
  logic [4:0] slot_bit;
  logic [2:0] slot;
  logic [4:0] obit;
  logic left_half;

  assign raw = '{mclk: bus_master_clk, wclk: bus_word_clk,
                 line: octal_in_line, all_mute_n: all_mute_n,
                 cs_n: slot_select_n, addr: backplane_addr_bit,
                 dir: transfer_direction, strobe_n: transfer_strobe_n,
                 data: backplane_data_bus_in};

  // edges seen on the synchronised copies only
  assign mrise = st_reg.s2.mclk & ~st_reg.mclk_d;
  assign wrise = st_reg.s2.wclk & ~st_reg.wclk_d;
  assign wr_fire = st_reg.s2.strobe_n & ~st_reg.strobe_d &
                   ~st_reg.s2.cs_n & ~st_reg.s2.dir;
  assign src = st_reg.ctl[oad_pkg::CTL_SRC_HI:oad_pkg::CTL_SRC_LO];

  // octal pair multiplexer, first line odd channels, second even
  always_comb begin
    case (src)
      oad_pkg::SRC_PAIR_0_1: begin
        line_odd = st_reg.s2.line[0];
        line_even = st_reg.s2.line[1];
      end
      oad_pkg::SRC_PAIR_8_9: begin
        line_odd = st_reg.s2.line[2];
        line_even = st_reg.s2.line[3];
      end
      oad_pkg::SRC_PAIR_10_11: begin
        line_odd = st_reg.s2.line[4];
        line_even = st_reg.s2.line[5];
      end
      default: begin
        line_odd = 1'b0;
        line_even = 1'b0;
      end
    endcase
  end

  // serial audio bit for one converter at output bit index idx
  function automatic logic conv_bit(input logic [23:0] smp,
                                    input logic [4:0] idx,
                                    input logic left);
    logic b;
    b = 1'b0;
    // one bit-clock delay after the frame sync edge, msb first;
    // only sample bits are complemented, padding stays zero
    if (idx != 5'h0 && idx <= 5'(oad_pkg::SAMPLE_W)) begin
      b = smp[5'(oad_pkg::SAMPLE_W) - idx];
      b = left ? ~b : b;
    end
    conv_bit = b;
  endfunction : conv_bit

  always_comb begin
    st_next = st_reg;
    slot_bit = st_reg.cnt[5:1];
    slot = st_reg.cnt[8:6];
    half_start = 1'b0;
    obit = 5'h0;
    left_half = 1'b0;
    // two-stage synchronisers, first stage read only by the second
    st_next.s1 = raw;
    st_next.s2 = st_reg.s1;
    st_next.mclk_d = st_reg.s2.mclk;
    st_next.wclk_d = st_reg.s2.wclk;
    st_next.strobe_d = st_reg.s2.strobe_n;

    // register port
    if (wr_fire && st_reg.s2.addr == oad_pkg::ADDR_CARD_CONTROL) begin
      st_next.ctl = st_reg.s2.data;
    end
    // identity register ignores writes
    st_next.rdata = (st_reg.s2.addr == oad_pkg::ADDR_CARD_CONTROL) ?
                    st_reg.ctl : BOARD_IDENTITY;

    // master clock edge count, restarted by the word clock
    if (wrise) begin
      st_next.cnt = '0;
    end else if (mrise) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end

    // octal bit sampled in the second master clock of each bit
    if (mrise && !wrise && !st_reg.cnt[0]) begin
      if (slot_bit < 5'(oad_pkg::SAMPLE_W)) begin
        st_next.sh_odd = {st_reg.sh_odd[22:0], line_odd};
        st_next.sh_even = {st_reg.sh_even[22:0], line_even};
      end
      // slot done: single speed keeps only the last four slots
      if (slot_bit == oad_pkg::SLOT_LAST_BIT &&
          (slot[2] || st_reg.ctl[oad_pkg::CTL_DOUBLE])) begin
        st_next.captured[{slot[1:0], 1'b0}] = st_reg.sh_odd;
        st_next.captured[{slot[1:0], 1'b1}] = st_reg.sh_even;
      end
    end

    // converter frame start: once per word clock, twice at double rate
    if (st_reg.ctl[oad_pkg::CTL_DOUBLE]) begin
      half_start = (st_next.cnt[7:0] == 8'h0) &&
                   (st_reg.cnt[7:0] != 8'h0);
      obit = st_next.cnt[6:2];
      left_half = ~st_next.cnt[7];
    end else begin
      half_start = (st_next.cnt == '0) && (st_reg.cnt != '0);
      obit = st_next.cnt[7:3];
      left_half = ~st_next.cnt[8];
    end
    if (half_start) begin
      st_next.hold = st_reg.captured;
    end

    for (int ch = 0; ch < oad_pkg::NUM_CH; ch++) begin
      st_next.dout[ch] = st_reg.s2.all_mute_n &
                         conv_bit(st_next.hold[ch], obit,
                                  left_half);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.ctl <= oad_pkg::CTL_RESET;
      st_reg.rdata <= BOARD_IDENTITY;
    end else if (en) begin
      st_reg <= st_next;
    end
  end

  // control outputs straight from the control register
  assign emphasis_undo_en = st_reg.ctl[oad_pkg::CTL_EMPH];
  assign relay_mute_n = st_reg.ctl[oad_pkg::CTL_RELAY];
  assign converter_reset_n = st_reg.ctl[oad_pkg::CTL_CONV_RST];
  assign converter_soft_mute = st_reg.ctl[oad_pkg::CTL_SOFT_MUTE];
  assign double_rate_en = st_reg.ctl[oad_pkg::CTL_DOUBLE];

  // read data driven only while selected, reading and strobe low
  assign backplane_data_bus_out = st_reg.rdata;
  assign backplane_data_bus_oe = ~st_reg.s2.cs_n & st_reg.s2.dir &
                                 ~st_reg.s2.strobe_n;

  // converter clocks; master clock half the bus clock at both rates
  assign conv_master_clk = st_reg.cnt[0];
  assign conv_bit_clk_n = st_reg.ctl[oad_pkg::CTL_DOUBLE] ?
                          st_reg.cnt[1] : st_reg.cnt[2];
  assign conv_frame_sync_n = st_reg.ctl[oad_pkg::CTL_DOUBLE] ?
                             st_reg.cnt[7] : st_reg.cnt[8];
  assign conv_serial_data = st_reg.dout;

  property p_ctl_write;
    @(posedge clk) disable iff (!nrst)
    (en && wr_fire && st_reg.s2.addr) |=>
      st_reg.ctl == $past(st_reg.s2.data);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not latched");

  property p_id_write;
    @(posedge clk) disable iff (!nrst)
    (en && wr_fire && !st_reg.s2.addr) |=> $stable(st_reg.ctl);
  endproperty
  a_id_write: assert property (p_id_write)
    else $error("identity write changed control");

  property p_ctl_outputs;
    @(posedge clk) disable iff (!nrst)
    (en && wr_fire && st_reg.s2.addr) |=>
      relay_mute_n == $past(st_reg.s2.data[3]) &&
      converter_reset_n == $past(st_reg.s2.data[2]) &&
      emphasis_undo_en == $past(st_reg.s2.data[4]) &&
      converter_soft_mute == $past(st_reg.s2.data[1]) &&
      double_rate_en == $past(st_reg.s2.data[0]);
  endproperty
  a_ctl_outputs: assert property (p_ctl_outputs)
    else $error("control outputs do not follow write");

  property p_reset_defaults;
    @(posedge clk) disable iff (1'b0)
    !nrst |=> st_reg.ctl == 8'h60 && !relay_mute_n && !converter_reset_n
              && !backplane_data_bus_oe && conv_serial_data == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("reset defaults wrong");

  sequence s_muted;
    en && !st_reg.s2.all_mute_n;
  endsequence
  property p_mute;
    @(posedge clk) disable iff (!nrst)
    s_muted |=> conv_serial_data == 8'h00;
  endproperty
  a_mute: assert property (p_mute)
    else $error("serial data not muted");

  property p_read_drive;
    @(posedge clk) disable iff (!nrst)
    backplane_data_bus_oe == (!st_reg.s2.cs_n && st_reg.s2.dir &&
                              !st_reg.s2.strobe_n);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("data bus drive wrong");

  property p_read_data;
    @(posedge clk) disable iff (!nrst)
    (en && !st_reg.s2.addr) |=> backplane_data_bus_out == BOARD_IDENTITY;
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("identity read wrong");

  sequence s_word_start;
    en && wrise;
  endsequence
  property p_frame_start;
    @(posedge clk) disable iff (!nrst)
    s_word_start |=> st_reg.cnt == '0 ##1 (!en || st_reg.cnt <= 9'h001);
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("octal frame not restarted");

  property p_fs_fall;
    @(posedge clk) disable iff (!nrst)
    ($fell(conv_frame_sync_n) && !double_rate_en &&
     !$past(double_rate_en)) |->
      st_reg.cnt[7:0] == 8'h00;
  endproperty
  a_fs_fall: assert property (p_fs_fall)
    else $error("frame sync fell mid frame");

  property p_mclk_toggle;
    @(posedge clk) disable iff (!nrst)
    (en && mrise && !wrise) |=> conv_master_clk != $past(conv_master_clk);
  endproperty
  a_mclk_toggle: assert property (p_mclk_toggle)
    else $error("master clock did not toggle");

endmodule : oad_dac_if

// ==== shared/oad_pkg.sv ====
/*
  oad_pkg: constants and packed types for the eight-channel analog output
  card interface logic.
  Assumes a single 10 MHz system clock. All backplane pins are asynchronous
  to it and pass through synchronisers before use.
*/
package oad_pkg;

  // register index, selected by the backplane address bit
  localparam logic ADDR_BOARD_IDENTITY = 1'b0;
  localparam logic ADDR_CARD_CONTROL = 1'b1;

  // card_control reset value and field positions
  localparam logic [7:0] CTL_RESET = 8'h60;
  localparam int CTL_SRC_HI = 6;
  localparam int CTL_SRC_LO = 5;
  localparam int CTL_EMPH = 4;
  localparam int CTL_RELAY = 3;
  localparam int CTL_CONV_RST = 2;
  localparam int CTL_SOFT_MUTE = 1;
  localparam int CTL_DOUBLE = 0;

  // board_identity field positions
  localparam int ID_TYPE_LO = 4;
  localparam int ID_REV_LO = 0;

  // source select encodings
  localparam logic [1:0] SRC_PAIR_0_1 = 2'h0;
  localparam logic [1:0] SRC_PAIR_8_9 = 2'h1;
  localparam logic [1:0] SRC_PAIR_10_11 = 2'h2;
  localparam logic [1:0] SRC_ZERO = 2'h3;

  // octal frame layout
  localparam int SAMPLE_W = 24;
  localparam int SLOT_BITS = 32;
  localparam int NUM_CH = 8;
  localparam int NUM_LINES = 6;
  localparam int SLOTS_PER_HALF = 4;
  localparam logic [4:0] SLOT_LAST_BIT = 5'h1f;

  // octal bit rate and bus master clock at 48 kHz word clock
  localparam int OCTAL_RATE_BPS = 12288000;
  localparam int MASTER_CLK_HZ = 24576000;
  localparam int MCLK_PER_OCTAL_BIT = MASTER_CLK_HZ / OCTAL_RATE_BPS;
  // master clock edges per word clock period
  localparam int MCLK_PER_FRAME = MCLK_PER_OCTAL_BIT * 8 * SLOT_BITS;
  localparam int CNT_W = $clog2(MCLK_PER_FRAME);

  // backplane and link pins, raw or synchronised
  typedef struct packed {
    logic mclk;
    logic wclk;
    logic [NUM_LINES-1:0] line;
    logic all_mute_n;
    logic cs_n;
    logic addr;
    logic dir;
    logic strobe_n;
    logic [7:0] data;
  } oad_pins_t;

  // complete state of the interface logic
  typedef struct packed {
    oad_pins_t s1;
    oad_pins_t s2;
    logic mclk_d;
    logic wclk_d;
    logic strobe_d;
    logic [7:0] ctl;
    logic [7:0] rdata;
    logic [CNT_W-1:0] cnt;
    logic [SAMPLE_W-1:0] sh_odd;
    logic [SAMPLE_W-1:0] sh_even;
    logic [NUM_CH-1:0][SAMPLE_W-1:0] captured;
    logic [NUM_CH-1:0][SAMPLE_W-1:0] hold;
    logic [NUM_CH-1:0] dout;
  } oad_state_t;

endpackage : oad_pkg

// ==== sim/oad_dac_if_tb.sv ====
/*
  oad_dac_if_tb: self-checking bench for the analog output card logic.
  Assumes the octal source model; the bench plays the backplane host.
*/
`timescale 1ns/100ps
module oad_dac_if_tb;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
  localparam logic [23:0] PAT = 24'h9c5a31;
  localparam realtime MPER = 820.0;
  logic clk, nrst, cs_n, addr, dir, strobe_n, all_mute_n;
  logic [7:0] host_d, bus_out, bus_in, sdata;
  logic bus_oe, mclk, wclk, emph, smute, crst_n, dbl, relay_n;
  logic mck_o, bck_n, fs_n;
  logic [5:0] lines;
  int miscompares, checked, cycles;

  assign bus_in = bus_oe ? bus_out : host_d;

  oad_octal_src #(.HALF(MPER / 2)) i_oad_octal_src (.pattern(PAT),
    .dbl(dbl),
    .bus_master_clk(mclk), .bus_word_clk(wclk), .octal_in_line(lines));

  oad_dac_if #(.BOARD_IDENTITY(ID_VAL)) i_oad_dac_if (.clk(clk),
    .nrst(nrst), .en(1'b1), .slot_select_n(cs_n),
    .backplane_addr_bit(addr), .transfer_direction(dir),
    .transfer_strobe_n(strobe_n), .backplane_data_bus_in(bus_in),
    .backplane_data_bus_out(bus_out), .backplane_data_bus_oe(bus_oe),
    .bus_master_clk(mclk), .bus_word_clk(wclk), .octal_in_line(lines),
    .all_mute_n(all_mute_n), .emphasis_undo_en(emph),
    .converter_soft_mute(smute), .converter_reset_n(crst_n),
    .double_rate_en(dbl), .relay_mute_n(relay_n),
    .conv_master_clk(mck_o), .conv_bit_clk_n(bck_n),
    .conv_frame_sync_n(fs_n), .conv_serial_data(sdata));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp_frame(input logic [7:0][23:0] got,
                           input logic [7:0][23:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t frame got %h exp %h", $time, got, exp);
    end
  endtask : cmp_frame

  task automatic cmp_time(input realtime got, input realtime exp);
    checked++;
    if (got < exp - 400 || got > exp + 400) begin
      miscompares++;
      $display("[FAIL] %0t period got %0t exp %0t", $time, got, exp);
    end
  endtask : cmp_time

  function automatic logic [7:0] pins();
    return {3'h0, emph, relay_n, crst_n, smute, dbl};
  endfunction : pins

  function automatic logic pick(input int w);
    return (w == 0) ? mck_o : bck_n;
  endfunction : pick

  // one host transfer; released data lines show the inverse value
  task automatic bus_cycle(input logic sel_n, input logic a,
                           input logic rd, input logic [7:0] d,
                           output logic [7:0] q);
    cs_n = sel_n;
    addr = a;
    dir = rd;
    host_d = rd ? ~host_d : d;
    repeat (4) @(negedge clk);
    strobe_n = 1'b0;
    repeat (5) @(negedge clk);
    q = bus_in;
    if (rd && !sel_n) cmp8({7'h0, bus_oe}, 8'h01);
    strobe_n = 1'b1;
    repeat (5) @(negedge clk);
    cmp8({7'h0, bus_oe}, 8'h00);
    cs_n = 1'b1;
    dir = 1'b1;
    host_d = ~host_d;
    repeat (2) @(negedge clk);
  endtask : bus_cycle

  task automatic reg_wr(input logic a, input logic [7:0] d);
    logic [7:0] q;
    bus_cycle(1'b0, a, 1'b0, d, q);
  endtask : reg_wr

  task automatic reg_chk(input logic a, input logic [7:0] e);
    logic [7:0] q;
    bus_cycle(1'b0, a, 1'b1, 8'h00, q);
    cmp8(q, e);
  endtask : reg_chk

  task automatic per_chk(input int w, input realtime e);
    realtime t0;
    logic p;
    int n;
    n = 0;
    t0 = 0;
    p = pick(w);
    repeat (300) begin
      @(negedge clk);
      if (p && !pick(w)) begin
        n++;
        if (n == 2) break;
        t0 = $realtime;
      end
      p = pick(w);
    end
    cmp_time((n == 2) ? $realtime - t0 : 0.0, e);
  endtask : per_chk

  // collect one converter frame from frame sync fall to the next
  task automatic grab(output logic [7:0][23:0] lw, output logic [7:0][23:0] rw,
                      output realtime tf, output logic [7:0] junk);
    logic pb, pf;
    int j, n;
    realtime t0;
    lw = '0;
    rw = '0;
    junk = 8'h00;
    tf = 0;
    j = 0;
    n = 0;
    pf = 1'b0;
    while (!(pf && !fs_n) && n < 9000) begin
      pf = fs_n;
      n++;
      @(negedge clk);
    end
    t0 = $realtime;
    pb = bck_n;
    pf = fs_n;
    repeat (4300) begin
      @(negedge clk);
      if (pf && !fs_n) begin
        tf = $realtime - t0;
        break;
      end
      if (pf != fs_n) j = 0;
      if (!pb && bck_n) begin
        for (int c = 0; c < 8; c++) begin
          if (j < 1 || j > 24) junk[c] = junk[c] | sdata[c];
          else if (fs_n) rw[c][24 - j] = sdata[c];
          else lw[c][24 - j] = sdata[c];
        end
        j++;
      end
      pb = bck_n;
      pf = fs_n;
    end
  endtask : grab

  task automatic t_reset();
    cmp8(pins(), 8'h00);
    cmp8(sdata, 8'h00);
    reg_chk(1'b0, ID_VAL);
    reg_chk(1'b1, 8'h60);
  endtask : t_reset

  task automatic t_ctl();
    logic [7:0] v;
    for (int b = 0; b < 5; b++) begin
      v = 8'h60 | (8'h01 << b);
      reg_wr(1'b1, v);
      cmp8(pins(), v & 8'h1f);
      reg_chk(1'b1, v);
    end
    reg_wr(1'b0, 8'hff);
    reg_chk(1'b0, ID_VAL);
    bus_cycle(1'b1, 1'b1, 1'b0, 8'h00, v);
    reg_chk(1'b1, 8'h70);
  endtask : t_ctl

  task automatic t_audio(input logic [1:0] src, input logic dbl_en,
                         input logic mute_n);
    logic [7:0][23:0] lw, rw, ex;
    logic [7:0] junk;
    realtime tf;
    for (int i = 0; i < 8; i++)
      ex[i] = (src == 2'h3) ? 24'h0 :
        PAT ^ 24'(((2 * int'(src) + i % 2) << 8) + ((4 + i / 2) << 4));
    all_mute_n = mute_n;
    reg_wr(1'b1, {1'b0, src, 4'h6, dbl_en});
    cmp8(pins(), {3'h0, 4'h6, dbl_en});
    repeat (mute_n ? 9000 : 10) @(negedge clk);
    grab(lw, rw, tf, junk);
    cmp_frame(rw, mute_n ? ex : '0);
    cmp_frame(lw, mute_n ? ~ex : '0);
    cmp8(junk, 8'h00);
    cmp_time(tf, (dbl_en ? 256 : 512) * MPER);
    per_chk(0, 2 * MPER);
    per_chk(1, (dbl_en ? 4 : 8) * MPER);
  endtask : t_audio

  initial begin
    cycles = 0;
    miscompares = 0;
    checked = 0;
    nrst = 1'b0;
    cs_n = 1'b1;
    addr = 1'b0;
    dir = 1'b1;
    strobe_n = 1'b1;
    host_d = 8'h00;
    all_mute_n = 1'b1;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_ctl();
    t_audio(2'h0, 1'b0, 1'b1);
    t_audio(2'h1, 1'b1, 1'b1);
    t_audio(2'h2, 1'b0, 1'b1);
    t_audio(2'h3, 1'b0, 1'b1);
    t_audio(2'h2, 1'b0, 1'b0);
    end_sim();
  end
endmodule : oad_dac_if_tb

// ==== sim/oad_octal_src.sv ====
/*
  oad_octal_src: octal line source with bus master and word clocks.
  Assumes nothing of its surroundings; runs free from time zero.
*/
`timescale 1ns/100ps
module oad_octal_src #(
  parameter realtime HALF = 410.0
) (
  // sample pattern
  input wire logic [23:0] pattern,
  // double rate: slots 0-3 repeat the tags of slots 4-7
  input wire logic dbl,
  // bus clocks and octal lines
  output logic bus_master_clk,
  output logic bus_word_clk,
  output logic [5:0] octal_in_line
);
  int m;

  // bit k of line l: sample msb first, then status bits held high
  function automatic logic obit(input int l, input int k);
    logic [23:0] s;
    s = pattern ^ 24'((l << 8) + ((dbl ? k / 32 % 4 + 4 : k / 32) << 4));
    return (k % 32 < 24) ? s[23 - k % 32] : 1'b1;
  endfunction : obit

  // slowed bit rate so clk can track it; two master clocks a bit
  initial begin
    bus_master_clk = 1'b0;
    bus_word_clk = 1'b0;
    octal_in_line = '0;
    m = 0;
    forever begin
      #(HALF);
      bus_master_clk = 1'b1;
      bus_word_clk = (m < 256);
      #(HALF);
      bus_master_clk = 1'b0;
      m = (m + 1) % 512;
      for (int l = 0; l < 6; l++) octal_in_line[l] = obit(l, m / 2);
    end
  end
endmodule : oad_octal_src
